// >>> rtl/pesc_pkg.sv
// package: register map, field layout and carrier types of the event block
package pesc_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_STAT1  = 8'h12;
    localparam logic [7:0]  IDX_STAT2  = 8'h13;
    localparam logic [7:0]  IDX_FCC    = 8'h14;
    localparam logic [7:0]  IDX_REC    = 8'h15;
    localparam logic [31:0] ADDR_STAT1 = {22'h000000, IDX_STAT1, 2'h0};
    localparam logic [31:0] ADDR_STAT2 = {22'h000000, IDX_STAT2, 2'h0};
    localparam logic [31:0] ADDR_FCC   = {22'h000000, IDX_FCC, 2'h0};
    localparam logic [31:0] ADDR_REC   = {22'h000000, IDX_REC, 2'h0};

    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int          BIT_UV       = 15;
    localparam int          BIT_OV       = 14;
    localparam int          BIT_OT       = 11;
    localparam int          BIT_SLEEP    = 10;
    localparam int          BIT_POL      = 9;
    localparam int          BIT_JAB      = 8;
    localparam int          BIT_FC_HF    = 9;
    localparam int          BIT_RE_HF    = 8;
    localparam int          EN_SHIFT     = 8;
    localparam logic [15:0] STAT2_FLAGS  = 16'hCF00;
    localparam logic [15:0] STAT2_ENS    = 16'h00CF;
    localparam logic [15:0] STAT1_FLAGS  = 16'h0300;
    localparam logic [15:0] STAT1_ENS    = 16'h0003;
    localparam logic [15:0] RST_STAT     = 16'h0000;
    localparam logic [31:0] RST_RDATA    = 32'h00000000;

    // ------------------------------------------------------------
    // counter widths
    // ------------------------------------------------------------
    localparam int          FC_WIDTH     = 8;
    localparam int          RE_WIDTH     = 16;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic underVolt;
        logic overVolt;
        logic overTemp;
        logic sleepEvt;
        logic rxPolarity;
        logic jabber;
        logic falseCarrier;
        logic rxDv;
        logic rxInvalidSym;
        logic macLoopback;
    } pesc_evt_s;

    typedef struct packed {
        logic [15:0] stat1;
        logic [15:0] stat2;
        logic        wrStat1;
        logic        wrStat2;
        logic [31:0] hrdata;
        logic        hready;
        logic        irq;
        logic        polPrev;
        logic        polValid;
    } pesc_state_s;

endpackage

// >>> rtl/pesc_sat_counter.sv
// saturating clear-on-read event counter with a half-full event
`timescale 1ns/100ps
module pesc_sat_counter
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             incr,
    input  wire logic             clear,
    output logic [WIDTH-1:0]      count,
    output logic                  halfEvt
);

    localparam logic [WIDTH-1:0] MAXV  = '1;
    localparam logic [WIDTH-1:0] HALFV = MAXV >> 1;
    localparam logic [WIDTH-1:0] ONE   = {{(WIDTH-1){1'b0}}, 1'b1};

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // ------------------------------------------------------------
    // next count
    // ------------------------------------------------------------
    always_comb
    begin
        count_d = count_q;
        if (clear)
        begin
            // an event in the read cycle survives the clear
            count_d = incr ? ONE : '0;
        end
        else if (incr && count_q != MAXV)
        begin
            count_d = count_q + ONE;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            count_q <= '0;
        else
            count_q <= count_d;
    end

    assign count   = count_q;
    // one pulse as the count passes from half to half plus one
    assign halfEvt = incr && !clear && count_q == HALFV;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_sat_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (count_q == MAXV && !clear) |=> count_q == MAXV)
        else $error("saturated counter moved");

    chk_count_step: assert property (
        @(posedge clock) disable iff (sys_rst)
        (incr && !clear && count_q != MAXV) |=>
            count_q == $past(count_q) + ONE)
        else $error("counter did not step by one");

    chk_read_clear: assert property (
        @(posedge clock) disable iff (sys_rst)
        (clear && !incr) |=> count_q == '0)
        else $error("counter not cleared by read");

    chk_half_event: assert property (
        @(posedge clock) disable iff (sys_rst)
        halfEvt |=> count_q == HALFV + ONE)
        else $error("half event at wrong count");

endmodule

// >>> rtl/pesc_event_counters.sv
// event status, enable and error counter register bank on ahb-lite
`timescale 1ns/100ps
module pesc_event_counters
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire pesc_pkg::pesc_evt_s  evt,
    output logic                      intReq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pesc_pkg::pesc_state_s s_q;
    pesc_pkg::pesc_state_s s_d;

    logic                          addrPhase;
    logic                          rdStrobe;
    logic                          wrStrobe;
    logic                          hitStat1;
    logic                          hitStat2;
    logic                          hitFcc;
    logic                          hitRec;
    logic                          polChange;
    logic                          fcInc;
    logic                          reInc;
    logic                          fcHalf;
    logic                          reHalf;
    logic [pesc_pkg::FC_WIDTH-1:0] fcCount;
    logic [pesc_pkg::RE_WIDTH-1:0] reCount;
    logic [15:0]                   set2;
    logic [15:0]                   set1;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // every transfer is taken with no wait state; hsize is not
    // checked since only whole words are mapped
    assign addrPhase = hsel && htrans[1] && hready;
    assign rdStrobe  = addrPhase && !hwrite;
    assign wrStrobe  = addrPhase && hwrite;
    assign hitStat1  = haddr == pesc_pkg::ADDR_STAT1;
    assign hitStat2  = haddr == pesc_pkg::ADDR_STAT2;
    assign hitFcc    = haddr == pesc_pkg::ADDR_FCC;
    assign hitRec    = haddr == pesc_pkg::ADDR_REC;

    // ------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------
    // the first sample after reset only seeds the history, so a
    // pin that powers up high is not taken for a change
    assign polChange = s_q.polValid
                       && evt.rxPolarity != s_q.polPrev;
    assign fcInc     = evt.falseCarrier;
    assign reInc     = evt.rxDv && evt.rxInvalidSym
                       && !evt.macLoopback;

    always_comb
    begin
        set2                     = 16'h0000;
        set2[pesc_pkg::BIT_UV]    = evt.underVolt;
        set2[pesc_pkg::BIT_OV]    = evt.overVolt;
        set2[pesc_pkg::BIT_OT]    = evt.overTemp;
        set2[pesc_pkg::BIT_SLEEP] = evt.sleepEvt;
        set2[pesc_pkg::BIT_POL]   = polChange;
        set2[pesc_pkg::BIT_JAB]   = evt.jabber;
        set1                     = 16'h0000;
        set1[pesc_pkg::BIT_FC_HF] = fcHalf;
        set1[pesc_pkg::BIT_RE_HF] = reHalf;
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    pesc_sat_counter
    #(
        .WIDTH (pesc_pkg::FC_WIDTH)
    )
    u_false_carrier
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .incr    (fcInc),
        .clear   (rdStrobe && hitFcc),
        .count   (fcCount),
        .halfEvt (fcHalf)
    );

    // the maximum is taken as all ones of the 16-bit field
    pesc_sat_counter
    #(
        .WIDTH (pesc_pkg::RE_WIDTH)
    )
    u_receive_error
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .incr    (reInc),
        .clear   (rdStrobe && hitRec),
        .count   (reCount),
        .halfEvt (reHalf)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.hready   = 1'b1;
        s_d.polPrev  = evt.rxPolarity;
        s_d.polValid = 1'b1;

        // latched flags; a set in the read cycle wins over the clear
        if (rdStrobe && hitStat2)
            s_d.stat2 = (s_q.stat2 & pesc_pkg::STAT2_ENS)
                        | set2;
        else
            s_d.stat2 = s_q.stat2 | set2;
        if (rdStrobe && hitStat1)
            s_d.stat1 = (s_q.stat1 & pesc_pkg::STAT1_ENS)
                        | set1;
        else
            s_d.stat1 = s_q.stat1 | set1;

        // write data phase: only the enable bits take the data
        if (s_q.wrStat2)
            s_d.stat2 = (s_d.stat2 & pesc_pkg::STAT2_FLAGS)
                        | (hwdata[15:0] & pesc_pkg::STAT2_ENS);
        if (s_q.wrStat1)
            s_d.stat1 = (s_d.stat1 & pesc_pkg::STAT1_FLAGS)
                        | (hwdata[15:0] & pesc_pkg::STAT1_ENS);
        s_d.wrStat2 = wrStrobe && hitStat2;
        s_d.wrStat1 = wrStrobe && hitStat1;

        // read data is captured at the address phase edge, the
        // same edge that performs any clear on read
        s_d.hrdata = pesc_pkg::RST_RDATA;
        if (rdStrobe)
        begin
            if (hitStat2)
                s_d.hrdata = {16'h0000, s_q.stat2};
            else if (hitStat1)
                s_d.hrdata = {16'h0000, s_q.stat1};
            else if (hitFcc)
                s_d.hrdata = {24'h000000, fcCount};
            else if (hitRec)
                s_d.hrdata = {16'h0000, reCount};
        end

        // registered from the next state so it moves with the flags
        s_d.irq = |((s_d.stat2 >> pesc_pkg::EN_SHIFT) & s_d.stat2
                    & pesc_pkg::STAT2_ENS)
                  || |((s_d.stat1 >> pesc_pkg::EN_SHIFT) & s_d.stat1
                    & pesc_pkg::STAT1_ENS);
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q          <= '0;
            s_q.stat1    <= pesc_pkg::RST_STAT;
            s_q.stat2    <= pesc_pkg::RST_STAT;
            s_q.hrdata   <= pesc_pkg::RST_RDATA;
            s_q.hready   <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata    = s_q.hrdata;
    assign hreadyout = s_q.hready;
    assign hresp     = 1'b0;
    assign intReq    = s_q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_uv_latch: assert property (
        @(posedge clock) disable iff (sys_rst)
        evt.underVolt |=> s_q.stat2[pesc_pkg::BIT_UV] [*2]
            or (s_q.stat2[pesc_pkg::BIT_UV]
                ##1 $past(rdStrobe && hitStat2)))
        else $error("undervoltage flag not latched");

    chk_ov_latch: assert property (
        @(posedge clock) disable iff (sys_rst)
        evt.overVolt |=> s_q.stat2[pesc_pkg::BIT_OV])
        else $error("overvoltage flag not set");

    chk_ot_latch: assert property (
        @(posedge clock) disable iff (sys_rst)
        evt.overTemp |=> s_q.stat2[pesc_pkg::BIT_OT])
        else $error("overtemperature flag not set");

    chk_sleep_latch: assert property (
        @(posedge clock) disable iff (sys_rst)
        evt.sleepEvt |=> s_q.stat2[pesc_pkg::BIT_SLEEP])
        else $error("sleep flag not set");

    chk_pol_change: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.polValid && $changed(evt.rxPolarity))
            |=> s_q.stat2[pesc_pkg::BIT_POL])
        else $error("polarity change not latched");

    chk_jab_latch: assert property (
        @(posedge clock) disable iff (sys_rst)
        evt.jabber |=> s_q.stat2[pesc_pkg::BIT_JAB])
        else $error("jabber flag not set");

    chk_flag_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2[pesc_pkg::BIT_JAB] && !(rdStrobe && hitStat2))
            |=> s_q.stat2[pesc_pkg::BIT_JAB])
        else $error("latched flag dropped without a read");

    chk_uv_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2[pesc_pkg::BIT_UV] && !(rdStrobe && hitStat2))
            |=> s_q.stat2[pesc_pkg::BIT_UV])
        else $error("undervoltage flag dropped without a read");

    chk_ov_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2[pesc_pkg::BIT_OV] && !(rdStrobe && hitStat2))
            |=> s_q.stat2[pesc_pkg::BIT_OV])
        else $error("overvoltage flag dropped without a read");

    chk_ot_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2[pesc_pkg::BIT_OT] && !(rdStrobe && hitStat2))
            |=> s_q.stat2[pesc_pkg::BIT_OT])
        else $error("overtemperature flag dropped without a read");

    chk_sleep_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2[pesc_pkg::BIT_SLEEP] && !(rdStrobe && hitStat2))
            |=> s_q.stat2[pesc_pkg::BIT_SLEEP])
        else $error("sleep flag dropped without a read");

    chk_pol_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2[pesc_pkg::BIT_POL] && !(rdStrobe && hitStat2))
            |=> s_q.stat2[pesc_pkg::BIT_POL])
        else $error("polarity flag dropped without a read");

    chk_enable_write: assert property (
        @(posedge clock) disable iff (sys_rst)
        s_q.wrStat2 |=> (s_q.stat2 & pesc_pkg::STAT2_ENS)
            == ($past(hwdata[15:0]) & pesc_pkg::STAT2_ENS))
        else $error("enable bits not written");

    chk_reserved_zero: assert property (
        @(posedge clock) disable iff (sys_rst)
        (s_q.stat2 & ~(pesc_pkg::STAT2_ENS | pesc_pkg::STAT2_FLAGS))
            == 16'h0000)
        else $error("reserved status bits set");

    chk_fc_top_zero: assert property (
        @(posedge clock) disable iff (sys_rst)
        (rdStrobe && hitFcc) |=> s_q.hrdata[31:8] == 24'h000000
            && s_q.hrdata[7:0] == $past(fcCount))
        else $error("false carrier read data wrong");

    chk_loop_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        (evt.macLoopback && !(rdStrobe && hitRec))
            |=> reCount == $past(reCount))
        else $error("receive errors counted in loopback");

    chk_rec_read: assert property (
        @(posedge clock) disable iff (sys_rst)
        (rdStrobe && hitRec && !reInc) |=>
            s_q.hrdata[15:0] == $past(reCount) && reCount == 16'h0000)
        else $error("receive error read not cleared");

    chk_fc_half: assert property (
        @(posedge clock) disable iff (sys_rst)
        fcHalf |=> s_q.stat1[pesc_pkg::BIT_FC_HF])
        else $error("false carrier half-full not latched");

    chk_re_half: assert property (
        @(posedge clock) disable iff (sys_rst)
        reHalf |=> s_q.stat1[pesc_pkg::BIT_RE_HF])
        else $error("receive error half-full not latched");

    chk_read_clear: assert property (
        @(posedge clock) disable iff (sys_rst)
        (rdStrobe && hitStat2 && set2 == 16'h0000)
            |=> (s_q.stat2 & pesc_pkg::STAT2_FLAGS) == 16'h0000)
        else $error("status flags not cleared by read");

    chk_stat1_clear: assert property (
        @(posedge clock) disable iff (sys_rst)
        (rdStrobe && hitStat1 && set1 == 16'h0000)
            |=> (s_q.stat1 & pesc_pkg::STAT1_FLAGS) == 16'h0000)
        else $error("first status flags not cleared by read");

    chk_irq_level: assert property (
        @(posedge clock) disable iff (sys_rst)
        intReq == (|((s_q.stat2 >> pesc_pkg::EN_SHIFT) & s_q.stat2
                     & pesc_pkg::STAT2_ENS)
                   || |((s_q.stat1 >> pesc_pkg::EN_SHIFT) & s_q.stat1
                     & pesc_pkg::STAT1_ENS)))
        else $error("interrupt request disagrees with flags");

endmodule

// >>> tb/phy_event_status_counters_tb.sv
// self-checking bench of the event status and error counter register bank
`timescale 1ns/100ps
module phy_event_status_counters_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                clock;
    logic                sys_rst;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic                hready;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    pesc_pkg::pesc_evt_s evt;
    logic                intReq;
    logic [31:0]         seed;
    logic [31:0]         r;
    logic [15:0]         en;
    logic [15:0]         fcExp;
    logic [15:0]         reExp;
    int                  bad_count;
    int                  comparisons;
    int                  bits [6];

    assign hready = hreadyout;

    pesc_event_counters pesc_event_counters_inst
    (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .evt       (evt),
        .intReq    (intReq)
    );

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // registers occupy the low half-word, the top half reads zero
    function automatic logic [31:0] word_of(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one whole ahb-lite single transfer, waits bounded on hready
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        int n;
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        n = 0;
        do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            finish_test();
        end
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 50);
        d = hrdata;
        if (n >= 50)
        begin
            bad_count++;
            finish_test();
        end
        comparisons++;
        if (hresp !== 1'b0)
        begin
            bad_count++;
            $display("BAD %0t error response", $time);
        end
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [15:0] v,
                          input string what);
        logic [31:0] d;
        bus(1'b0, a, 32'h00000000, d);
        chk(d, word_of(v), what);
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [15:0] v);
        logic [31:0] d;
        bus(1'b1, a, rnd() & 32'hFFFF0000 | {16'h0000, v}, d);
    endtask

    // counters see every cycle that the input stands high
    task automatic fc_pulses(input int n);
        @(posedge clock);
        evt.falseCarrier <= 1'b1;
        repeat (n) @(posedge clock);
        evt.falseCarrier <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (90000) @(posedge clock);
        bad_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h3302864A;
        bad_count = 0;
        comparisons = 0;
        bits = '{pesc_pkg::BIT_UV, pesc_pkg::BIT_OV, pesc_pkg::BIT_OT,
                 pesc_pkg::BIT_SLEEP, pesc_pkg::BIT_POL, pesc_pkg::BIT_JAB};
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        evt = '0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;

        rd_chk(pesc_pkg::ADDR_STAT1, 16'h0000, "stat1 reset");
        rd_chk(pesc_pkg::ADDR_STAT2, 16'h0000, "stat2 reset");
        rd_chk(pesc_pkg::ADDR_FCC, 16'h0000, "fc reset");
        rd_chk(pesc_pkg::ADDR_REC, 16'h0000, "re reset");
        wr_reg(32'h00000058, 16'hFFFF);
        rd_chk(32'h00000058, 16'h0000, "unmapped");
        wr_reg(pesc_pkg::ADDR_STAT2, 16'hFFFF);
        rd_chk(pesc_pkg::ADDR_STAT2, 16'h00CF, "enable mask");
        $display("test registers done");

        // each event with a random enable set
        for (int k = 0; k < 6; k++)
        begin
            r = rnd();
            en = r[15:0] & pesc_pkg::STAT2_ENS;
            wr_reg(pesc_pkg::ADDR_STAT2, en);
            @(posedge clock);
            case (k)
                0: evt.underVolt <= 1'b1;
                1: evt.overVolt <= 1'b1;
                2: evt.overTemp <= 1'b1;
                3: evt.sleepEvt <= 1'b1;
                4: evt.rxPolarity <= ~evt.rxPolarity;
                default: evt.jabber <= 1'b1;
            endcase
            @(posedge clock);
            evt.underVolt <= 1'b0;
            evt.overVolt <= 1'b0;
            evt.overTemp <= 1'b0;
            evt.sleepEvt <= 1'b0;
            evt.jabber <= 1'b0;
            repeat (3) @(posedge clock);
            #1;
            chk({31'h0, intReq}, {31'h0, en[bits[k] - 8]}, "irq gate");
            rd_chk(pesc_pkg::ADDR_STAT2, en | (16'h0001 << bits[k]),
                   "flag latched");
            rd_chk(pesc_pkg::ADDR_STAT2, en, "flag cleared");
            #1;
            chk({31'h0, intReq}, 32'h00000000, "irq drop");
        end
        wr_reg(pesc_pkg::ADDR_STAT2, 16'h0000);
        // a flag raised in the clearing read's cycle must survive it
        fork
            rd_chk(pesc_pkg::ADDR_STAT2, 16'h0000, "set vs clear");
            begin
                @(posedge clock);
                evt.jabber <= 1'b1;
                @(posedge clock);
                evt.jabber <= 1'b0;
            end
        join
        rd_chk(pesc_pkg::ADDR_STAT2, 16'h0100, "set wins");
        $display("test events done");

        // random false carriers and receive errors, loopback among them
        fcExp = 16'h0000;
        reExp = 16'h0000;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clock);
            r = rnd();
            evt.falseCarrier <= r[0];
            evt.rxDv <= r[1];
            evt.rxInvalidSym <= r[2];
            evt.macLoopback <= r[3] & r[4];
            fcExp += {15'h0000, r[0]};
            if (r[1] & r[2] & ~(r[3] & r[4]))
                reExp++;
        end
        @(posedge clock);
        evt <= '0;
        rd_chk(pesc_pkg::ADDR_FCC, fcExp, "fc count");
        rd_chk(pesc_pkg::ADDR_FCC, 16'h0000, "fc clear");
        rd_chk(pesc_pkg::ADDR_REC, reExp, "re count");
        rd_chk(pesc_pkg::ADDR_REC, 16'h0000, "re clear");
        $display("test counting done");

        // half-full boundary of the false carrier counter
        fc_pulses(127);
        rd_chk(pesc_pkg::ADDR_STAT1, 16'h0000, "fc at 7f");
        fc_pulses(1);
        repeat (2) @(posedge clock);
        rd_chk(pesc_pkg::ADDR_STAT1, 16'h0200, "fc at 80");
        rd_chk(pesc_pkg::ADDR_FCC, 16'h0080, "fc 80");
        // a false carrier in the clearing read's cycle counts as one
        fork
            rd_chk(pesc_pkg::ADDR_FCC, 16'h0000, "fc read inc");
            fc_pulses(1);
        join
        rd_chk(pesc_pkg::ADDR_FCC, 16'h0001, "fc after inc");
        $display("test half full done");

        // both counters driven into saturation
        wr_reg(pesc_pkg::ADDR_STAT1, 16'h0001);
        @(posedge clock);
        evt.falseCarrier <= 1'b1;
        evt.rxDv <= 1'b1;
        evt.rxInvalidSym <= 1'b1;
        repeat (65540) @(posedge clock);
        evt <= '0;
        repeat (3) @(posedge clock);
        #1;
        chk({31'h0, intReq}, 32'h00000001, "irq re half");
        rd_chk(pesc_pkg::ADDR_FCC, 16'h00FF, "fc sat");
        rd_chk(pesc_pkg::ADDR_REC, 16'hFFFF, "re sat");
        rd_chk(pesc_pkg::ADDR_STAT1, 16'h0301, "stat1 half");
        rd_chk(pesc_pkg::ADDR_STAT1, 16'h0001, "stat1 clear");
        #1;
        chk({31'h0, intReq}, 32'h00000000, "irq off");
        $display("test saturation done");
        finish_test();
    end
endmodule
